// ### logic/micro_skip_defs.svh
// Constants of the microinstruction skip sequencer: offsets, fields, resets.
//
// Overview of operation
// - Skipped instruction still issues, forced to no-op.
// - Address-select code skips if either select set.
// - Carry code skips on ALU carry-out.
// - Counter-full code tests low four bits only.
// - Incrementing counter-full tests, then increments counter.
// - Phase end jumps through mapper after one instruction.
// - Phase end clears the subroutine flip-flop unless a call shares its cycle.
// - Phase end acts even when its instruction nullified.
// - Flag code skips when CPU flag set.
// - Non-low-address code skips if T-bus 1..14 nonzero.
// - Sign code skips when ALU bit 15 set.
// - Uninverted protect-ok skips only with both selects clear.
// - Odd code skips when ALU bit 0 set.
// - Overflow code skips when overflow flip-flop set.
// - Repeat reissues next instruction until its skip.
// - Zero code skips when whole T-bus zero.
// - Uninverted unconditional code nullifies next instruction unless it ends a repeat.
// - Memory write suppressed while either select set.
// - Memory write starts only on true skip.
// - Memory read sets select flip-flop for register addresses.
// - Entering execute phase 3 increments program counter once.
// - Invert special code complements the skip sense.
// - Subroutine call sets the subroutine flip-flop.
`ifndef MICRO_SKIP_DEFS_SVH
`define MICRO_SKIP_DEFS_SVH

// ==================================================
// Datapath widths
`define TBUS_W          16
`define CTR_W           5
`define CTR_FULL_LOW    4'hF

// ==================================================
// Register bus
`define AXI_AW          4
`define OFF_CTRL        4'h0
`define OFF_STATUS      4'h4
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`define CTRL_PROT_EN    0
`define CTRL_RESET      1'h0

// ==================================================
// Status word fields
`define ST_CTR_LSB      0
`define ST_A_SEL        5
`define ST_B_SEL        6
`define ST_SUB          7
`define ST_PHASE_LSB    8
`define ST_REPEAT       10
`define ST_NULLIFY      11

`endif

// ### logic/micro_skip_pkg.sv
// Types shared by the microinstruction skip sequencer.
`default_nettype none
`include "micro_skip_defs.svh"
package micro_skip_pkg;

  // Skip field codes.
  typedef enum logic [3:0] {
    SK_NOP, SK_ADDR_SELECT, SK_CARRY, SK_CTR_FULL, SK_CTR_FULL_INCR,
    SK_CTR_INCR, SK_PHASE_END, SK_FLAG, SK_NONLOW, SK_SIGN, SK_PROT_OK,
    SK_ODD, SK_OVF, SK_REPEAT, SK_ZERO, SK_ALWAYS
  } skip_code_t;

  // Special field codes that touch this block.
  typedef enum logic [2:0] {
    SP_NOP, SP_INVERT, SP_MEM_WRITE, SP_MEM_READ, SP_ADDR_SET, SP_CTR_LOAD
  } special_t;

  // Machine phases; PH_EXEC is phase 3.
  typedef enum logic [1:0] {PH_FETCH, PH_INDIRECT, PH_EXEC, PH_EXEC4} phase_t;

  // Decoded microinstruction as issued from control store.
  typedef struct packed {
    skip_code_t skip;
    special_t   spec;
    logic       sub_call;
    logic       sub_return;
    phase_t     next_phase;
    logic [3:0] ctr_load;
  } micro_instr_t;

  // ALU and T-bus state of the current cycle.
  typedef struct packed {
    logic                carry;
    logic                msb;
    logic                lsb;
    logic [`TBUS_W-1:0]  t_bus;
  } alu_status_t;

  // Processor flip-flops sampled by the skip tests.
  typedef struct packed {
    logic cpu_flag;
    logic overflow;
    logic prot_viol;
  } cpu_state_t;

endpackage
`default_nettype wire

// ### logic/micro_skip_sequencer.sv
// Skip, repeat, phase-end and memory-cycle gating of the micro sequencer.
//
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "micro_skip_defs.svh"
module micro_skip_sequencer (
  // Clock and reset
  input  wire logic                        sys_clk_i,
  input  wire logic                        rst_i,
  // Microinstruction stream, one per machine cycle
  input  wire logic                        mi_valid_i,
  input  wire micro_skip_pkg::micro_instr_t mi_i,
  input  wire micro_skip_pkg::alu_status_t alu_i,
  input  wire micro_skip_pkg::cpu_state_t  cpu_i,
  // Sequencer controls
  output logic                             nullify_o,
  output logic                             repeat_o,
  output logic                             map_jump_o,
  output logic                             inc_pc_o,
  output logic                             sub_ff_o,
  output micro_skip_pkg::phase_t           phase_o,
  output logic [`CTR_W-1:0]                counter_o,
  // Register select and memory control
  output logic                             a_select_o,
  output logic                             b_select_o,
  output logic                             mem_write_start_o,
  output logic                             mem_read_start_o,
  // AXI4-Lite slave
  input  wire logic [`AXI_AW-1:0]          s_axi_awaddr_i,
  input  wire logic                        s_axi_awvalid_i,
  output logic                             s_axi_awready_o,
  input  wire logic [31:0]                 s_axi_wdata_i,
  input  wire logic [3:0]                  s_axi_wstrb_i,
  input  wire logic                        s_axi_wvalid_i,
  output logic                             s_axi_wready_o,
  output logic [1:0]                       s_axi_bresp_o,
  output logic                             s_axi_bvalid_o,
  input  wire logic                        s_axi_bready_i,
  input  wire logic [`AXI_AW-1:0]          s_axi_araddr_i,
  input  wire logic                        s_axi_arvalid_i,
  output logic                             s_axi_arready_o,
  output logic [31:0]                      s_axi_rdata_o,
  output logic [1:0]                       s_axi_rresp_o,
  output logic                             s_axi_rvalid_o,
  input  wire logic                        s_axi_rready_i
);
  import micro_skip_pkg::*;

  // ==================================================
  // State
  logic               null_r;
  logic               rpt_r;
  logic               eop_pend_r;
  phase_t             nph_r;
  phase_t             phase_r;
  logic               jump_r;
  logic               inc_pc_r;
  logic               sub_r;
  logic [`CTR_W-1:0]  ctr_r;
  logic               a_sel_r;
  logic               b_sel_r;
  logic               wr_start_r;
  logic               rd_start_r;
  logic               ctrl_r;
  logic               eff;
  logic               sel_any;
  logic               nonlow;
  logic               cond;
  logic               is_test;
  logic               skip_set;
  logic               eop_hit;
  logic [1:0]         sel_nxt;

  // Returns {b, a}: a register location only when the high bits are zero.
  function automatic logic [1:0] sel_decode(input logic hi_zero, input logic low);
    sel_decode = hi_zero ? (low ? 2'h2 : 2'h1) : 2'h0;
  endfunction

  // Register index of an address: 0 control, 1 status, 2 unmapped.
  function automatic logic [1:0] reg_index(input logic [`AXI_AW-1:0] addr);
    if (addr == `OFF_CTRL) begin
      reg_index = 2'h0;
    end else if (addr == `OFF_STATUS) begin
      reg_index = 2'h1;
    end else begin
      reg_index = 2'h2;
    end
  endfunction

  // ==================================================
  // Skip condition evaluation
  // A nullified instruction still arrives; of its fields only a phase-end skip code acts.
  assign eff     = mi_valid_i & ~null_r;
  assign sel_any = a_sel_r | b_sel_r;
  assign nonlow  = |alu_i.t_bus[`TBUS_W-2:1];
  assign eop_hit = mi_valid_i & (mi_i.skip == SK_PHASE_END);

  // Raw condition per skip code; codes that only act set no test.
  always_comb begin
    cond    = 1'b0;
    is_test = 1'b1;
    unique case (mi_i.skip)
      SK_ADDR_SELECT:   cond = sel_any;
      SK_CARRY:         cond = alu_i.carry;
      SK_CTR_FULL:      cond = (ctr_r[3:0] == `CTR_FULL_LOW);
      SK_CTR_FULL_INCR: cond = (ctr_r[3:0] == `CTR_FULL_LOW);
      SK_FLAG:          cond = cpu_i.cpu_flag;
      SK_NONLOW:        cond = nonlow;
      SK_SIGN:          cond = alu_i.msb;
      SK_PROT_OK:       cond = ~sel_any & (~ctrl_r | ~cpu_i.prot_viol);
      SK_ODD:           cond = alu_i.lsb;
      SK_OVF:           cond = cpu_i.overflow;
      SK_ZERO:          cond = ~|alu_i.t_bus;
      SK_ALWAYS:        cond = 1'b1;
      SK_NOP, SK_CTR_INCR, SK_PHASE_END, SK_REPEAT: is_test = 1'b0;
    endcase
  end

  // The invert code flips whatever test the same instruction carries.
  assign skip_set = eff & is_test & (cond ^ (mi_i.spec == SP_INVERT));

  // ==================================================
  // Nullify and repeat
  // The decision is registered so the next issued instruction is the one
  // forced to a no-op; a skip that ends a repeat loop nullifies nothing.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      null_r <= 1'b0;
    end else if (mi_valid_i) begin
      null_r <= skip_set & ~rpt_r;
    end
  end

  // Repeat holds while the repeated instruction's own test stays false.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rpt_r <= 1'b0;
    end else if (mi_valid_i) begin
      if (rpt_r) begin
        rpt_r <= ~skip_set;
      end else begin
        rpt_r <= eff & (mi_i.skip == SK_REPEAT);
      end
    end
  end

  // ==================================================
  // Phase end and mapper jump
  // The jump waits one instruction, so the line after the phase end runs.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      eop_pend_r <= 1'b0;
      nph_r      <= PH_FETCH;
      jump_r     <= 1'b0;
      phase_r    <= PH_FETCH;
    end else begin
      jump_r <= 1'b0;
      if (mi_valid_i) begin
        eop_pend_r <= eop_hit;
        if (eop_hit) begin
          nph_r <= mi_i.next_phase;
        end
        if (eop_pend_r) begin
          jump_r  <= 1'b1;
          phase_r <= nph_r;
        end
      end
    end
  end

  // Program counter step fires once, on the cycle phase 3 is entered.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      inc_pc_r <= 1'b0;
    end else begin
      inc_pc_r <= mi_valid_i & eop_pend_r & (nph_r == PH_EXEC) & (phase_r != PH_EXEC);
    end
  end

  // ==================================================
  // Subroutine flip-flop
  // A call in the same cycle as a clear wins, so the return stays locked.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sub_r <= 1'b0;
    end else if (eff & mi_i.sub_call) begin
      sub_r <= 1'b1;
    end else if (eop_hit | (eff & mi_i.sub_return)) begin
      sub_r <= 1'b0;
    end
  end

  // ==================================================
  // Loop counter
  // Bit 4 only records wrap of the low nibble; tests ignore it.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctr_r <= '0;
    end else if (eff & (mi_i.spec == SP_CTR_LOAD)) begin
      ctr_r <= {1'b0, mi_i.ctr_load};
    end else if (eff & ((mi_i.skip == SK_CTR_FULL_INCR) | (mi_i.skip == SK_CTR_INCR))) begin
      ctr_r <= ctr_r + `CTR_W'(1);
    end
  end

  // ==================================================
  // Register select flip-flops
  // Memory read tests the address; the set code tests ALU bit 0 instead.
  always_comb begin
    sel_nxt = {b_sel_r, a_sel_r};
    if (eff & (mi_i.spec == SP_MEM_READ)) begin
      sel_nxt = sel_decode(~nonlow & ~alu_i.t_bus[`TBUS_W-1], alu_i.t_bus[0]);
    end else if (eff & (mi_i.spec == SP_ADDR_SET)) begin
      sel_nxt = sel_decode(~nonlow, alu_i.lsb);
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      a_sel_r <= 1'b0;
      b_sel_r <= 1'b0;
    end else begin
      a_sel_r <= sel_nxt[0];
      b_sel_r <= sel_nxt[1];
    end
  end

  // ==================================================
  // Memory cycle requests
  // A write into location 0 or 1 lands in A or B, never in core.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_start_r <= 1'b0;
      rd_start_r <= 1'b0;
    end else begin
      wr_start_r <= eff & (mi_i.spec == SP_MEM_WRITE) & skip_set & ~sel_any;
      rd_start_r <= eff & (mi_i.spec == SP_MEM_READ);
    end
  end

  // ==================================================
  // AXI4-Lite slave
  logic               awready_r;
  logic               wready_r;
  logic               bvalid_r;
  logic [1:0]         bresp_r;
  logic [`AXI_AW-1:0] waddr_r;
  logic [31:0]        wdata_r;
  logic               wstrb0_r;
  logic               arready_r;
  logic               rvalid_r;
  logic [1:0]         rresp_r;
  logic [31:0]        rdata_r;
  logic               do_write;
  logic [31:0]        status;

  assign do_write = ~awready_r & ~wready_r & ~bvalid_r;

  // Live state word for software.
  always_comb begin
    status                                 = '0;
    status[`ST_CTR_LSB +: `CTR_W]          = ctr_r;
    status[`ST_A_SEL]                      = a_sel_r;
    status[`ST_B_SEL]                      = b_sel_r;
    status[`ST_SUB]                        = sub_r;
    status[`ST_PHASE_LSB +: 2]             = phase_r;
    status[`ST_REPEAT]                     = rpt_r;
    status[`ST_NULLIFY]                    = null_r;
  end

  // Address and data are taken in either order and held until the answer.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `RESP_OKAY;
      waddr_r   <= '0;
      wdata_r   <= '0;
      wstrb0_r  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i & awready_r) begin
        awready_r <= 1'b0;
        waddr_r   <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i & wready_r) begin
        wready_r <= 1'b0;
        wdata_r  <= s_axi_wdata_i;
        wstrb0_r <= s_axi_wstrb_i[0];
      end
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r  <= (reg_index(waddr_r) == 2'h2) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (bvalid_r & s_axi_bready_i) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // Control word: protect enable steers the protect-ok test.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_r <= `CTRL_RESET;
    end else if (do_write & wstrb0_r & (reg_index(waddr_r) == 2'h0)) begin
      ctrl_r <= wdata_r[`CTRL_PROT_EN];
    end
  end

  // Reads answer one cycle after the address is taken.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rresp_r   <= `RESP_OKAY;
      rdata_r   <= '0;
    end else if (s_axi_arvalid_i & arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rresp_r   <= `RESP_OKAY;
      unique case (reg_index(s_axi_araddr_i))
        2'h0:    rdata_r <= {31'h0, ctrl_r};
        2'h1:    rdata_r <= status;
        default: begin
          rdata_r <= '0;
          rresp_r <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r & s_axi_rready_i) begin
      rvalid_r  <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ==================================================
  // Output drive
  assign nullify_o         = null_r;
  assign repeat_o          = rpt_r;
  assign map_jump_o        = jump_r;
  assign inc_pc_o          = inc_pc_r;
  assign sub_ff_o          = sub_r;
  assign phase_o           = phase_r;
  assign counter_o         = ctr_r;
  assign a_select_o        = a_sel_r;
  assign b_select_o        = b_sel_r;
  assign mem_write_start_o = wr_start_r;
  assign mem_read_start_o  = rd_start_r;
  assign s_axi_awready_o   = awready_r;
  assign s_axi_wready_o    = wready_r;
  assign s_axi_bvalid_o    = bvalid_r;
  assign s_axi_bresp_o     = bresp_r;
  assign s_axi_arready_o   = arready_r;
  assign s_axi_rvalid_o    = rvalid_r;
  assign s_axi_rresp_o     = rresp_r;
  assign s_axi_rdata_o     = rdata_r;

  // ==================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  a_always_nullify: assert property (
    eff && !rpt_r && mi_i.skip == SK_ALWAYS && mi_i.spec != SP_INVERT |=> null_r)
    else $error("unconditional skip did not nullify next instruction");

  a_null_blocks: assert property (
    null_r && mi_valid_i |=> !wr_start_r && !rd_start_r)
    else $error("nullified instruction started a memory cycle");

  a_ctr_full_test: assert property (
    eff && !rpt_r && mi_i.skip == SK_CTR_FULL && mi_i.spec == SP_NOP
      && ctr_r[3:0] == 4'hF |=> null_r)
    else $error("counter-full test missed low nibble all ones");

  a_ctr_incr: assert property (
    eff && mi_i.skip == SK_CTR_FULL_INCR && mi_i.spec != SP_CTR_LOAD
      |=> ctr_r == $past(ctr_r) + 5'h01)
    else $error("counter not incremented after test");

  a_eop_delay: assert property (
    eop_hit ##1 (mi_valid_i && !eop_hit) |=> jump_r ##1 !jump_r)
    else $error("mapper jump not one instruction after phase end");

  a_eop_nullified: assert property (
    mi_valid_i && null_r && mi_i.skip == SK_PHASE_END |=> eop_pend_r)
    else $error("nullified phase end was dropped");

  a_eop_sub_clear: assert property (
    eop_hit && !(eff && mi_i.sub_call) |=> !sub_r)
    else $error("phase end left subroutine flip-flop set");

  a_prot_sel_block: assert property (
    eff && !rpt_r && mi_i.skip == SK_PROT_OK && mi_i.spec != SP_INVERT
      && sel_any |=> !null_r)
    else $error("protect-ok skipped with a select set");

  a_write_gate: assert property (
    wr_start_r |-> $past(skip_set) && !$past(sel_any))
    else $error("memory write started without skip or with select");

  a_read_select: assert property (
    eff && mi_i.spec == SP_MEM_READ && alu_i.t_bus == 16'h0001
      |=> b_sel_r && !a_sel_r && rd_start_r)
    else $error("read of location 1 did not select B");

  a_pc_step: assert property (
    $changed(phase_r) && phase_r == PH_EXEC |-> inc_pc_r)
    else $error("phase 3 entry without program counter step");

  c_repeat_loop:   cover property (rpt_r [*3] ##1 !rpt_r);
  c_phase_jump:    cover property (eop_hit ##1 mi_valid_i ##1 jump_r);
  c_write_started: cover property (wr_start_r);
  c_null_eop:      cover property (mi_valid_i && null_r && eop_hit);

endmodule // micro_skip_sequencer
`default_nettype wire

// ### verification/ctrl_store_model.sv
// Control store model that issues a loaded microprogram, one word per machine cycle.
`timescale 1ns/100ps
`default_nettype none
module ctrl_store_model (
  // Clock and reset
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  // Sequencing
  input  wire logic                  run_i,
  input  wire logic                  repeat_i,
  // Issued word
  output logic                       mi_valid_o,
  output micro_skip_pkg::micro_instr_t mi_o
);
  import micro_skip_pkg::*;
  micro_instr_t rom [32];
  logic [4:0]   pc_r;
  // ==========================================================
  // Fetch
  // The address holds while the issued word is under repeat. A stopped store shows
  // a changing word, so nothing downstream may lean on a stale value.
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mi_valid_o <= 1'b0;
      mi_o       <= '0;
      pc_r       <= 5'h00;
    end else if (!run_i) begin
      mi_valid_o <= 1'b0;
      mi_o       <= ~mi_o;
      pc_r       <= 5'h00;
    end else if (!repeat_i) begin
      mi_valid_o <= 1'b1;
      mi_o       <= rom[pc_r];
      pc_r       <= pc_r + 5'h01;
    end
  end
endmodule  // ctrl_store_model
`default_nettype wire

// ### verification/tb.sv
// Self-checking bench of the micro skip sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "micro_skip_defs.svh"
module tb;
  import micro_skip_pkg::*;
  // ==========================================================
  // Signals
  typedef struct packed {skip_code_t s; logic [18:0] a; logic [2:0] c; logic e;} row_t;
  logic               sys_clk_i, rst_i, run, mi_valid, nullify, repeat_next, jump, inc_pc, sub_ff, a_sel, b_sel;
  logic               wr_st, rd_st, awvalid, awready, wvalid, wready, bvalid, bready;
  logic               arvalid, arready, rvalid, rready;
  micro_instr_t       mi;
  alu_status_t        alu;
  cpu_state_t         cpu;
  phase_t             phase;
  logic [`CTR_W-1:0]  ctr;
  logic [`AXI_AW-1:0] awaddr, araddr;
  logic [31:0]        wdata, rdata;
  logic [1:0]         bresp, rresp;
  int                 mismatches, n_compared;
  // ==========================================================
  // Instances
  ctrl_store_model cs (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .run_i(run), .repeat_i(repeat_next),
    .mi_valid_o(mi_valid), .mi_o(mi));
  micro_skip_sequencer dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .mi_valid_i(mi_valid), .mi_i(mi),
    .alu_i(alu), .cpu_i(cpu), .nullify_o(nullify), .repeat_o(repeat_next), .map_jump_o(jump), .inc_pc_o(inc_pc),
    .sub_ff_o(sub_ff), .phase_o(phase), .counter_o(ctr), .a_select_o(a_sel), .b_select_o(b_sel),
    .mem_write_start_o(wr_st), .mem_read_start_o(rd_st), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  // Free-running 100 MHz clock.
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  function automatic micro_instr_t ins(skip_code_t s, special_t p = SP_NOP);
    ins = '0;
    ins.skip = s;
    ins.spec = p;
  endfunction
  // Unused store words read as plain no-ops, so a stray tail never acts.
  task automatic go(input micro_instr_t p[$]);
    foreach (cs.rom[i]) cs.rom[i] = '0;
    foreach (p[i]) cs.rom[i] = p[i];
    @(posedge sys_clk_i) run <= 1'b1;
  endtask
  task automatic stop();
    @(posedge sys_clk_i) run <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
  endtask
  // Each channel is released only at the edge where its ready is seen high.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge sys_clk_i) begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
    end
    // The raised strobes only land after this time step, so test at the loop's foot.
    do begin
      @(posedge sys_clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bready <= 1'b0;
        check(bresp, er);
      end
    end while (awvalid || wvalid || bready);
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge sys_clk_i) begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
    end
    do begin
      @(posedge sys_clk_i);
      if (arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        check({rresp, rdata}, {er, ed});
      end
    end while (arvalid || rready);
  endtask
  // ==========================================================
  // Scenarios
  task automatic skip_codes();
    row_t rows [15] = '{'{SK_CARRY, 19'h40001, 3'h0, 1'b1}, '{SK_CARRY, 19'h00001, 3'h0, 1'b0},
      '{SK_FLAG, 19'h00001, 3'h4, 1'b1}, '{SK_FLAG, 19'h00001, 3'h3, 1'b0}, '{SK_OVF, 19'h00001, 3'h2, 1'b1},
      '{SK_NONLOW, 19'h00002, 3'h0, 1'b1}, '{SK_NONLOW, 19'h08001, 3'h0, 1'b0}, '{SK_SIGN, 19'h20000, 3'h0, 1'b1},
      '{SK_SIGN, 19'h1FFFF, 3'h0, 1'b0}, '{SK_ODD, 19'h10000, 3'h0, 1'b1}, '{SK_ODD, 19'h0FFFF, 3'h0, 1'b0},
      '{SK_ZERO, 19'h70000, 3'h0, 1'b1}, '{SK_ZERO, 19'h08000, 3'h0, 1'b0}, '{SK_ALWAYS, 19'h00001, 3'h0, 1'b1},
      '{SK_PROT_OK, 19'h00001, 3'h1, 1'b1}};
    foreach (rows[i]) for (int v = 0; v < 2; v++) begin
      @(posedge sys_clk_i) begin
        alu <= rows[i].a;
        cpu <= rows[i].c;
      end
      go('{ins(rows[i].s, v ? SP_INVERT : SP_NOP)});
      repeat (2) tick();
      check(nullify, rows[i].e ^ v[0]);
      stop();
    end
  endtask
  task automatic counter();
    micro_instr_t p[$];
    p.push_back(ins(SK_NOP, SP_CTR_LOAD));
    p[0].ctr_load = 4'hE;
    repeat (17) p.push_back(ins(SK_CTR_INCR));
    p = {p, ins(SK_CTR_FULL), ins(SK_NOP), ins(SK_CTR_FULL_INCR), ins(SK_NOP), ins(SK_CTR_FULL)};
    go(p);
    repeat (19) tick();
    check(ctr, 5'h1F);
    tick();
    check({nullify, ctr}, 6'h3F);
    repeat (2) tick();
    check({nullify, ctr}, 6'h20);
    repeat (2) tick();
    check(nullify, 1'b0);
    stop();
  endtask
  task automatic phase_end();
    micro_instr_t p[$];
    p = '{ins(SK_NOP), ins(SK_ALWAYS), ins(SK_PHASE_END), ins(SK_NOP), ins(SK_NOP), ins(SK_PHASE_END)};
    p[0].sub_call = 1'b1;
    p[2].next_phase = PH_EXEC;
    p[5].next_phase = PH_EXEC4;
    go(p);
    repeat (2) tick();
    check(sub_ff, 1'b1);
    tick();
    check(nullify, 1'b1);
    tick();
    check({nullify, jump}, 2'b00);
    tick();
    check({jump, inc_pc, sub_ff, phase}, {3'b110, PH_EXEC});
    tick();
    check({jump, inc_pc}, 2'b00);
    repeat (2) tick();
    check({jump, inc_pc, phase}, {2'b10, PH_EXEC4});
    stop();
  endtask
  // The repeated word holds no zero test and no add-type function.
  task automatic repeat_loop();
    @(posedge sys_clk_i) alu <= '0;
    go('{ins(SK_REPEAT), ins(SK_ODD)});
    repeat (2) tick();
    check(repeat_next, 1'b1);
    @(posedge sys_clk_i) alu.lsb <= 1'b1;
    #1;
    check({repeat_next, nullify}, 2'b10);
    @(posedge sys_clk_i) alu.lsb <= 1'b0;
    #1;
    check({repeat_next, nullify}, 2'b00);
    tick();
    check(nullify, 1'b0);
    stop();
  endtask
  task automatic mem(input logic [15:0] t, input logic [1:0] sel, input logic w);
    @(posedge sys_clk_i) alu <= {3'b000, t};
    go('{ins(SK_NOP, SP_MEM_READ), ins(SK_PROT_OK, SP_MEM_WRITE), ins(SK_ALWAYS), ins(SK_NOP), ins(SK_ADDR_SELECT)});
    repeat (2) tick();
    check({rd_st, a_sel, b_sel}, {1'b1, sel});
    tick();
    check({wr_st, nullify}, {w, w});
    tick();
    check(nullify, !w);
    repeat (2) tick();
    check(nullify, |sel);
    stop();
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    {rst_i, run, alu, cpu, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    axi_rd(`OFF_CTRL, 32'h0, `RESP_OKAY);
    skip_codes();
    counter();
    phase_end();
    repeat_loop();
    @(posedge sys_clk_i) cpu <= '0;
    mem(16'h0000, 2'b10, 1'b0);
    mem(16'h0001, 2'b01, 1'b0);
    axi_rd(`OFF_STATUS, 32'h0000_0340, `RESP_OKAY);
    axi_wr(`OFF_STATUS, 32'hFFFF_FFFF, `RESP_OKAY);
    axi_wr(4'h8, 32'h1, `RESP_SLVERR);
    axi_rd(4'hC, 32'h0, `RESP_SLVERR);
    mem(16'h0005, 2'b00, 1'b1);
    axi_wr(`OFF_CTRL, 32'h1, `RESP_OKAY);
    axi_rd(`OFF_CTRL, 32'h1, `RESP_OKAY);
    @(posedge sys_clk_i) cpu <= 3'b001;
    mem(16'h0005, 2'b00, 1'b0);
    @(posedge sys_clk_i) cpu <= 3'b000;
    mem(16'h0005, 2'b00, 1'b1);
    results();
  end
  // The sequence needs under four hundred cycles; ten thousand means a hang.
  initial begin
    #100000;
    mismatches++;
    results();
  end
endmodule  // tb
`default_nettype wire
